// ===== rtl/sbg_pkg.sv
package sbg_pkg;

  // ****************************************
  // Register map (byte addresses on APB)
  // ****************************************
  localparam logic [7:0] SBG_OFF_BAUD = 8'h00;    // baud_select_reg
  localparam logic [7:0] SBG_OFF_TX_FINE = 8'h04; // tx_fine_prescale_reg
  localparam logic [7:0] SBG_OFF_RX_FINE = 8'h08; // rx_fine_prescale_reg
  localparam logic [7:0] SBG_OFF_CTRL = 8'h0C;    // Enables, mute, wake select
  localparam logic [7:0] SBG_OFF_STAT = 8'h10;    // Sticky event flags, write one to clear
  localparam logic [7:0] SBG_OFF_MASK = 8'h14;    // Interrupt mask, same layout as status
  localparam logic [7:0] SBG_OFF_DATA = 8'h18;    // Last received word

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SBG_BAUD_COARSE_LSB = 6; // coarse_div_sel[1:0]
  localparam int SBG_BAUD_TX_LSB = 3;     // tx_div_sel[2:0]
  localparam int SBG_BAUD_RX_LSB = 0;     // rx_div_sel[2:0]
  localparam int SBG_CTRL_TX_EN = 0;      // Transmit rate enable
  localparam int SBG_CTRL_RX_EN = 1;      // Receiver enable
  localparam int SBG_CTRL_MUTE = 2;       // receiver_mute
  localparam int SBG_CTRL_WAKE = 3;       // 0 idle-line wake, 1 address-mark wake
  localparam int SBG_STAT_RX_WORD_READY_FLAG = 0;       // rx_word_ready_flag
  localparam int SBG_STAT_IDLE = 1;       // Idle line seen

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SBG_RST_BAUD = 8'h00;
  localparam logic [7:0] SBG_RST_FINE = 8'h00;
  localparam logic [3:0] SBG_RST_CTRL = 4'h0;
  localparam logic [1:0] SBG_RST_STAT = 2'h0;
  localparam logic [1:0] SBG_RST_MASK = 2'h0;

  // ****************************************
  // Divider and timing counts
  // ****************************************
  localparam logic [3:0] SBG_COARSE_F0 = 4'h1; // coarse_divider for select 0
  localparam logic [3:0] SBG_COARSE_F1 = 4'h3; // coarse_divider for select 1
  localparam logic [3:0] SBG_COARSE_F2 = 4'h4; // coarse_divider for select 2
  localparam logic [3:0] SBG_COARSE_F3 = 4'hD; // coarse_divider for select 3
  localparam logic [3:0] SBG_OS_LAST = 4'hF;   // Sixteen sample ticks per bit
  localparam logic [3:0] SBG_OS_MID = 4'h7;    // Start bit checked mid-way
  localparam logic [3:0] SBG_DATA_LAST = 4'h7; // Eight data bits per word
  localparam logic [7:0] SBG_IDLE_OS = 8'hA0;  // Ten bit times of sample ticks
  localparam int SBG_CNT_W = 19;               // Holds 255 * 13 * 128

  // Receiver sequence, one-hot
  typedef enum logic [3:0] {
    SBG_RX_IDLE = 4'h1,
    SBG_RX_START = 4'h2,
    SBG_RX_DATA = 4'h4,
    SBG_RX_STOP = 4'h8
  } sbg_rx_state_type;

endpackage

// ===== rtl/sbg_rate_gen.sv
module sbg_rate_gen
  import sbg_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n,   // Asynchronous reset, active low
  sbg_rate_if.gen rate      // Settings in, ticks out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [SBG_CNT_W-1:0] cnt; // Cycles within one sample tick
    logic [3:0] sixteenth;     // Sample ticks within one bit
    logic os_tick;             // Sample tick pulse
    logic bit_tick;            // Bit tick pulse
  } sbg_rate_state_type;

  sbg_rate_state_type st;
  sbg_rate_state_type next_st;
  logic [3:0] coarse;         // Selected coarse factor
  logic [SBG_CNT_W-1:0] prod; // Cycles per sample tick

  // Total division per sample tick; one counter serves all stages
  always_comb begin
    case (rate.coarse_sel)
      2'h0: coarse = SBG_COARSE_F0;
      2'h1: coarse = SBG_COARSE_F1;
      2'h2: coarse = SBG_COARSE_F2;
      default: coarse = SBG_COARSE_F3;
    endcase
    // Zero fine factor falls back to the conventional path
    prod = (rate.fine == 8'h00) ? SBG_CNT_W'(coarse) : SBG_CNT_W'(rate.fine) * SBG_CNT_W'(coarse);
    prod = prod << rate.div_sel;
  end

  // Next state; settings are read live every cycle, even mid-count, so software keeps them still while enabled
  always_comb begin
    next_st = st;
    next_st.os_tick = 1'b0;
    next_st.bit_tick = 1'b0;
    if (!rate.enable) begin
      // Stopped direction holds the divider at its start
      next_st.cnt = '0;
      next_st.sixteenth = 4'h0;
    end else if (st.cnt >= prod - SBG_CNT_W'(1)) begin
      next_st.cnt = '0;
      next_st.os_tick = 1'b1;
      next_st.sixteenth = st.sixteenth + 4'h1;
      next_st.bit_tick = (st.sixteenth == SBG_OS_LAST);
    end else begin
      next_st.cnt = st.cnt + SBG_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rate.os_tick = st.os_tick;
  assign rate.bit_tick = st.bit_tick;

  // ****************************************
  // Checks
  // ****************************************
  logic [SBG_CNT_W-1:0] gap; // Cycles since the last sample tick
  logic seen;                // A sample tick has been seen since enable

  // Helper that measures tick spacing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
      seen <= 1'b0;
    end else begin
      gap <= st.os_tick ? SBG_CNT_W'(1) : gap + SBG_CNT_W'(1);
      seen <= rate.enable && (seen || st.os_tick);
    end
  end

  a_os_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.os_tick && seen && $stable(prod) |-> gap == prod)
    else $error("sample tick spacing differs from the selected division");

  a_bit_on_os: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.bit_tick |-> st.os_tick && st.sixteenth == 4'h0)
    else $error("bit tick not aligned to the sixteenth sample tick");

  a_stopped_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rate.enable |=> !st.os_tick)
    else $error("disabled divider produced a tick");

endmodule

// ===== rtl/sbg_rate_if.sv
// ****************************************
// Rate generator settings and ticks
// ****************************************
interface sbg_rate_if;
  logic [1:0] coarse_sel; // Coarse division select
  logic [2:0] div_sel;    // Power-of-two divider select
  logic [7:0] fine;       // Fine factor, zero bypasses it
  logic enable;           // Direction enabled
  logic os_tick;          // Sixteenth-of-a-bit tick
  logic bit_tick;         // One tick per bit time
  modport gen (input coarse_sel, input div_sel, input fine, input enable, output os_tick, output bit_tick);
  modport user (output coarse_sel, output div_sel, output fine, output enable, input os_tick, input bit_tick);
endinterface

// ===== rtl/sbg_top.sv
module sbg_top
  import sbg_pkg::*;
(
  input wire logic clk_sys,        // System clock
  input wire logic rst_n,          // Asynchronous reset, active low
  input wire logic psel,           // APB select
  input wire logic penable,        // APB access phase
  input wire logic pwrite,         // APB write
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready
  output logic pslverr,            // APB error for unmapped address
  input wire logic rx_line,        // Serial receive line
  output logic irq,                // Level interrupt
  output logic tx_bit_tick,        // One pulse per transmit bit time
  output logic rx_bit_tick         // One pulse per receive bit time
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] baud;            // baud_select_reg
    logic [7:0] tx_fine;         // tx_fine_factor
    logic [7:0] rx_fine;         // rx_fine_factor
    logic tx_en;                 // Transmit rate running
    logic rx_en;                 // Receiver running
    logic mute;                  // receiver_mute
    logic wake_sel;              // Wake-up method
    logic [1:0] stat;            // Sticky flags
    logic [1:0] mask;            // Interrupt mask
    logic [7:0] rx_data;         // Last accepted word
    sbg_rx_state_type rx_state;  // Receiver sequence
    logic [3:0] os_cnt;          // Sample ticks within a bit
    logic [3:0] bit_cnt;         // Data bits taken
    logic [7:0] shift;           // Incoming word, LSB first
    logic [7:0] idle_cnt;        // Sample ticks of continuous high
    logic idle_armed;            // Next idle frame counts
    logic [31:0] prdata;         // Read data
    logic pready;                // Answer strobe
    logic pslverr;               // Error strobe
    logic irq;                   // Interrupt level
    logic tx_tick;               // Transmit bit tick copy
    logic rx_tick;               // Receive bit tick copy
  } sbg_top_state_type;

  sbg_top_state_type st;
  sbg_top_state_type next_st;

  sbg_rate_if tx_rate ();
  sbg_rate_if rx_rate ();

  // ****************************************
  // Rate generators
  // ****************************************
  // Coarse select is shared, the power-of-two and fine settings are per direction
  assign tx_rate.coarse_sel = st.baud[SBG_BAUD_COARSE_LSB +: 2];
  assign tx_rate.div_sel = st.baud[SBG_BAUD_TX_LSB +: 3];
  assign tx_rate.fine = st.tx_fine;
  assign tx_rate.enable = st.tx_en;
  assign rx_rate.coarse_sel = st.baud[SBG_BAUD_COARSE_LSB +: 2];
  assign rx_rate.div_sel = st.baud[SBG_BAUD_RX_LSB +: 3];
  assign rx_rate.fine = st.rx_fine;
  assign rx_rate.enable = st.rx_en;

  // Transmit direction divider
  sbg_rate_gen u_tx_rate (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .rate (tx_rate.gen)
  );

  // Receive direction divider
  sbg_rate_gen u_rx_rate (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .rate (rx_rate.gen)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic acc;            // Access phase present
  logic wr;             // Write completes this edge
  logic frame_done;     // Word with good stop bit
  logic idle_hit;       // Idle frame recognised
  logic wake;           // Hardware clears mute
  logic [1:0] set_stat; // Flags raised by hardware
  logic [1:0] clr_stat; // Flags cleared by software
  logic load_data;      // Capture shifted word

  always_comb begin
    next_st = st;
    acc = psel && penable;
    wr = acc && st.pready && pwrite;
    frame_done = 1'b0;
    idle_hit = 1'b0;
    wake = 1'b0;
    set_stat = 2'h0;
    clr_stat = 2'h0;
    load_data = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;

    // APB answer one cycle into the access phase; read data is latched with it
    if (acc && !st.pready) begin
      next_st.pready = 1'b1;
      if (paddr == SBG_OFF_BAUD) begin
        next_st.prdata = {24'h000000, st.baud};
      end else if (paddr == SBG_OFF_TX_FINE) begin
        next_st.prdata = {24'h000000, st.tx_fine};
      end else if (paddr == SBG_OFF_RX_FINE) begin
        next_st.prdata = {24'h000000, st.rx_fine};
      end else if (paddr == SBG_OFF_CTRL) begin
        next_st.prdata = {28'h0000000, st.wake_sel, st.mute, st.rx_en, st.tx_en};
      end else if (paddr == SBG_OFF_STAT) begin
        next_st.prdata = {30'h00000000, st.stat};
      end else if (paddr == SBG_OFF_MASK) begin
        next_st.prdata = {30'h00000000, st.mask};
      end else if (paddr == SBG_OFF_DATA) begin
        next_st.prdata = {24'h000000, st.rx_data};
      end else begin
        // Unmapped address answers with an error and zero data
        next_st.prdata = 32'h00000000;
        next_st.pslverr = 1'b1;
      end
    end

    // Receiver, stepped by the receive sample tick
    if (!st.rx_en) begin
      next_st.rx_state = SBG_RX_IDLE;
      next_st.os_cnt = 4'h0;
      next_st.bit_cnt = 4'h0;
      next_st.idle_cnt = 8'h00;
    end else if (rx_rate.os_tick) begin
      case (st.rx_state)
        SBG_RX_IDLE: begin
          if (!rx_line) begin
            // Possible start bit; any low breaks the idle count
            next_st.rx_state = SBG_RX_START;
            next_st.os_cnt = 4'h0;
            next_st.idle_cnt = 8'h00;
            next_st.idle_armed = 1'b1;
          end else if (st.idle_cnt != SBG_IDLE_OS) begin
            // A whole character time of high makes an idle frame
            next_st.idle_cnt = st.idle_cnt + 8'h01;
            idle_hit = st.idle_armed && (st.idle_cnt == SBG_IDLE_OS - 8'h01);
          end
        end
        SBG_RX_START: begin
          next_st.os_cnt = st.os_cnt + 4'h1;
          if (st.os_cnt == SBG_OS_MID) begin
            // A high mid-bit is noise, not a start bit
            next_st.rx_state = rx_line ? SBG_RX_IDLE : SBG_RX_DATA;
            next_st.os_cnt = 4'h0;
            next_st.bit_cnt = 4'h0;
          end
        end
        SBG_RX_DATA: begin
          next_st.os_cnt = st.os_cnt + 4'h1;
          if (st.os_cnt == SBG_OS_LAST) begin
            next_st.shift = {rx_line, st.shift[7:1]};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            if (st.bit_cnt == SBG_DATA_LAST) begin
              next_st.rx_state = SBG_RX_STOP;
            end
          end
        end
        SBG_RX_STOP: begin
          next_st.os_cnt = st.os_cnt + 4'h1;
          if (st.os_cnt == SBG_OS_LAST) begin
            // A low stop bit drops the word silently
            frame_done = rx_line;
            next_st.rx_state = SBG_RX_IDLE;
          end
        end
        default: begin
          next_st.rx_state = SBG_RX_IDLE;
        end
      endcase
    end

    // Word accepted: normally always, while muted only as an address mark
    if (frame_done) begin
      if (!st.mute) begin
        load_data = 1'b1;
        set_stat[SBG_STAT_RX_WORD_READY_FLAG] = 1'b1;
      end else if (st.wake_sel && st.shift[7]) begin
        wake = 1'b1;
        load_data = 1'b1;
        set_stat[SBG_STAT_RX_WORD_READY_FLAG] = 1'b1;
      end
    end

    // Idle frame: wakes a receiver muted for idle-line wake without raising the idle flag
    if (idle_hit) begin
      next_st.idle_armed = 1'b0;
      if (st.mute) begin
        wake = !st.wake_sel;
      end else begin
        set_stat[SBG_STAT_IDLE] = 1'b1;
      end
    end

    if (load_data) begin
      next_st.rx_data = st.shift;
    end
    if (wake) begin
      next_st.mute = 1'b0;
    end

    // Register writes take effect on the edge that samples pready
    if (wr) begin
      if (paddr == SBG_OFF_BAUD) begin
        next_st.baud = pwdata[7:0];
      end else if (paddr == SBG_OFF_TX_FINE) begin
        next_st.tx_fine = pwdata[7:0];
      end else if (paddr == SBG_OFF_RX_FINE) begin
        next_st.rx_fine = pwdata[7:0];
      end else if (paddr == SBG_OFF_CTRL) begin
        // A mute set by software wins over a wake in the same cycle
        next_st.tx_en = pwdata[SBG_CTRL_TX_EN];
        next_st.rx_en = pwdata[SBG_CTRL_RX_EN];
        next_st.mute = pwdata[SBG_CTRL_MUTE];
        next_st.wake_sel = pwdata[SBG_CTRL_WAKE];
      end else if (paddr == SBG_OFF_STAT) begin
        clr_stat = pwdata[1:0];
      end else if (paddr == SBG_OFF_MASK) begin
        next_st.mask = pwdata[1:0];
      end
    end

    // Sticky flags: a set in the clearing cycle survives the clear
    next_st.stat = (st.stat & ~clr_stat) | set_stat;

    // Interrupt held off entirely while muted
    next_st.irq = (|(st.stat & st.mask)) && !st.mute;
    next_st.tx_tick = tx_rate.bit_tick;
    next_st.rx_tick = rx_rate.bit_tick;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.baud <= SBG_RST_BAUD;
      st.tx_fine <= SBG_RST_FINE;
      st.rx_fine <= SBG_RST_FINE;
      {st.wake_sel, st.mute, st.rx_en, st.tx_en} <= SBG_RST_CTRL;
      st.stat <= SBG_RST_STAT;
      st.mask <= SBG_RST_MASK;
      st.rx_state <= SBG_RX_IDLE;
      st.idle_armed <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign tx_bit_tick = st.tx_tick;
  assign rx_bit_tick = st.rx_tick;

  // ****************************************
  // Checks
  // ****************************************
  a_mute_no_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st.stat[SBG_STAT_RX_WORD_READY_FLAG]) |-> !$past(st.mute) || ($past(st.wake_sel) && $past(st.shift[7])))
    else $error("ready flag raised by a muted receiver");

  a_mute_no_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st.stat[SBG_STAT_IDLE]) |-> !$past(st.mute))
    else $error("idle flag raised by a muted receiver");

  a_muted_no_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st.mute |=> !irq)
    else $error("interrupt raised while muted");

  a_idle_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_hit && st.mute && !st.wake_sel && !wr |=> !st.mute && !st.stat[SBG_STAT_IDLE])
    else $error("idle frame did not wake the receiver cleanly");

  a_addr_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_done && st.mute && st.wake_sel && st.shift[7] && !wr
    |=> !st.mute && st.stat[SBG_STAT_RX_WORD_READY_FLAG] && st.rx_data == $past(st.shift))
    else $error("address mark did not wake and deliver the word");

  a_idle_span: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_hit |-> st.idle_cnt == SBG_IDLE_OS - 8'h01 && rx_line)
    else $error("idle frame recognised before one character time");

  a_ready_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && !pready |=> pready ##1 !pready)
    else $error("APB answer not a single cycle one edge after access");

  // The error strobe only ever rides on an answer
  a_err_with_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error strobe without ready");

  // Write one to clear; a set in the same cycle is left out of the check
  a_stat_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr && paddr == SBG_OFF_STAT && set_stat == 2'h0 |=> (st.stat & $past(pwdata[1:0])) == 2'h0)
    else $error("status bits not cleared by a write of one");

  // Pending unmasked flag on an awake receiver raises the line next cycle
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|(st.stat & st.mask)) && !st.mute |=> irq)
    else $error("interrupt missing for a pending unmasked flag");

  // In address mode an idle frame must leave the receiver muted
  a_idle_no_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_hit && st.mute && st.wake_sel && !wr |=> st.mute)
    else $error("idle frame woke a receiver set for address wake");

  // A muted receiver keeps the last word it accepted
  a_mute_keeps_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_done && st.mute && !(st.wake_sel && st.shift[7]) |=> st.rx_data == $past(st.rx_data))
    else $error("muted receiver replaced the held word");

endmodule

// ===== verification/sbg_node_model.sv
// ****************************************
// Remote node sending frames on the line
// ****************************************
module sbg_node_model (
  input wire logic clk_sys, // System clock
  output logic rx_line      // Line towards the receiver
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_cycles = 16; // Clock cycles per bit, left at the fastest rate
  // Line rests high between frames, like the pulled-up bus
  initial rx_line = 1'b1;
  // One frame: start low, eight bits LSB first, stop high
  task automatic send_word(input logic [7:0] word);
    logic [9:0] frame;
    frame = {1'b1, word, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rx_line <= frame[i];
      repeat (bit_cycles - 1) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== verification/testbench.sv
// ****************************************
// Self-checking bench for the rate and mute block
// ****************************************
module testbench
  import sbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, psel, penable, pwrite; // Clock, reset, APB control
  logic [7:0] paddr; // APB address
  logic [31:0] pwdata, prdata, rd; // APB data and last read word
  logic pready, pslverr, irq, tx_bit_tick, rx_bit_tick, rx_line, err; // Outputs
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 55; // Fixed seed keeps runs repeatable
  int cycles = 0; // Hang guard counter

  sbg_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .irq(irq), .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick));
  sbg_node_model node (.clk_sys(clk_sys), .rx_line(rx_line));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares one result word
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check(32'h0, 32'h1);
  endtask

  // Read a register and compare it
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Interrupt level lags its cause by one cycle, so let an edge pass, then look away from the edge
  task automatic expect_irq(input logic exp);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  // Cycles between two tick pulses of one direction
  task automatic gap(input logic is_rx, output int n);
    int k;
    k = 0;
    while (k < 20000 && (is_rx ? rx_bit_tick : tx_bit_tick) !== 1'b1) begin
      @(posedge clk_sys);
      k++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (n < 20000 && (is_rx ? rx_bit_tick : tx_bit_tick) !== 1'b1);
  endtask

  // Expected bit time in clocks; zero fine factor means bypass
  function automatic int rate(input int c, input int s, input int f);
    int cf[4] = '{1, 3, 4, 13};
    return 16 * cf[c] * (1 << s) * ((f == 0) ? 1 : f);
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] b;
    int n, ft, fr, c;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, then an unmapped place
    for (int a = 0; a <= 24; a += 4) expect_reg(8'(a), 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("reset test done");
    // Every divider code, every coarse code, fine on and off
    for (int k = 0; k < 8; k++) begin
      c = 3 - k / 2;
      ft = (k % 2) ? ({$random(seed)} % 3) + 1 : 0;
      fr = (k % 2) ? 0 : ({$random(seed)} % 3) + 1;
      apb(1'b1, SBG_OFF_CTRL, 32'h0);
      apb(1'b1, SBG_OFF_BAUD, {24'h0, 2'(c), 3'(k), 3'(k ^ 1)});
      apb(1'b1, SBG_OFF_TX_FINE, 32'(ft));
      apb(1'b1, SBG_OFF_RX_FINE, 32'(fr));
      apb(1'b1, SBG_OFF_CTRL, 32'h3);
      gap(1'b0, n);
      check(32'(n), 32'(rate(c, k, ft)));
      gap(1'b1, n);
      check(32'(n), 32'(rate(c, k ^ 1, fr)));
      $display("rate test %0d done", k);
    end
    // Fastest rate: sixteen clocks per bit
    apb(1'b1, SBG_OFF_CTRL, 32'h0);
    apb(1'b1, SBG_OFF_BAUD, 32'h0);
    apb(1'b1, SBG_OFF_TX_FINE, 32'h0);
    apb(1'b1, SBG_OFF_RX_FINE, 32'h0);
    apb(1'b1, SBG_OFF_MASK, 32'h3);
    apb(1'b1, SBG_OFF_STAT, 32'h3); // Idle flag may be left over from the rate tests
    apb(1'b1, SBG_OFF_CTRL, 32'h2);
    b = 8'($random(seed));
    node.send_word(b);
    repeat (20) @(posedge clk_sys);
    expect_reg(SBG_OFF_STAT, 32'h1);
    expect_reg(SBG_OFF_DATA, {24'h0, b});
    expect_irq(1'b1);
    apb(1'b1, SBG_OFF_STAT, 32'h1);
    expect_irq(1'b0);
    // Idle needs a whole character of high line
    repeat (70) @(posedge clk_sys);
    expect_reg(SBG_OFF_STAT, 32'h0);
    repeat (90) @(posedge clk_sys);
    expect_reg(SBG_OFF_STAT, 32'h2);
    apb(1'b1, SBG_OFF_STAT, 32'h3);
    $display("receive test done");
    // Muted, idle wake: nothing flagged, mute cleared by the idle frame
    apb(1'b1, SBG_OFF_CTRL, 32'h6);
    node.send_word(8'($random(seed)));
    repeat (20) @(posedge clk_sys);
    expect_reg(SBG_OFF_STAT, 32'h0);
    expect_irq(1'b0);
    expect_reg(SBG_OFF_CTRL, 32'h6);
    repeat (200) @(posedge clk_sys);
    expect_reg(SBG_OFF_CTRL, 32'h2);
    expect_reg(SBG_OFF_STAT, 32'h0);
    $display("idle wake test done");
    // Muted, address wake: data word ignored, address word kept
    apb(1'b1, SBG_OFF_CTRL, 32'hE);
    node.send_word(8'h35);
    repeat (200) @(posedge clk_sys);
    expect_reg(SBG_OFF_STAT, 32'h0);
    expect_reg(SBG_OFF_CTRL, 32'hE);
    expect_irq(1'b0);
    b = 8'($random(seed)) | 8'h80;
    node.send_word(b);
    repeat (20) @(posedge clk_sys);
    expect_reg(SBG_OFF_CTRL, 32'hA);
    expect_reg(SBG_OFF_STAT, 32'h1);
    expect_reg(SBG_OFF_DATA, {24'h0, b});
    expect_irq(1'b1);
    $display("address wake test done");
    tally_and_finish();
  end
endmodule
